// ==== design/sac_pkg.sv ====
/*
  Shared constants and types for the converter control block: register
  offsets, control bit positions, reset values, sequencing counts and the
  bus carrier. Assumes a single 50 MHz system clock and an APB master with
  32-bit data.
*/
package sac_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] SAC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] SAC_OFF_RESULT = 8'h04;
  localparam logic [7:0] SAC_OFF_GT     = 8'h08;
  localparam logic [7:0] SAC_OFF_LT     = 8'h0C;
  localparam logic [7:0] SAC_OFF_DIV    = 8'h10;
  localparam logic [7:0] SAC_OFF_STAT   = 8'h14;

  // Bit positions in the control register.
  localparam int SAC_B_EN   = 7;
  localparam int SAC_B_TM   = 6;
  localparam int SAC_B_DONE = 5;
  localparam int SAC_B_BUSY = 4;
  localparam int SAC_B_SRC  = 2;
  localparam int SAC_B_WINT = 1;
  localparam int SAC_B_LJST = 0;

  // Values after reset.
  localparam logic [7:0]  SAC_CTRL_RST = 8'h00;
  localparam logic [15:0] SAC_GT_RST   = 16'hFFFF;
  localparam logic [15:0] SAC_LT_RST   = 16'h0000;
  localparam logic [4:0]  SAC_DIV_RST  = 5'h1F;

  // Result width in bits, sequencing counts in converter clocks, and the first trial code.
  localparam int SAC_RES_W      = 12;
  localparam int SAC_TRACK_CLKS = 3;
  localparam int SAC_CONV_CLKS  = 16;
  localparam logic [11:0] SAC_MSB_TRIAL = 12'h800;

  typedef enum logic [1:0] {
    SAC_SRC_SW,
    SAC_SRC_TMR3,
    SAC_SRC_PIN,
    SAC_SRC_TMR2
  } sac_src_t;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_TRACK,
    SAC_CONV
  } sac_phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sac_apb_req_t;

endpackage : sac_pkg

// ==== design/sac_sar.sv ====
/*
  Successive-approximation sequencer: one bit decided per converter clock for
  the first twelve of sixteen converter clocks per conversion. Assumes the comparator input is
  already synchronised and settles within one converter clock.
*/
module sac_sar (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic        cmp,
  output logic             done,
  output logic [11:0]      result,
  output logic [11:0]      dac_code
);

  typedef struct packed {
    logic        run;
    logic [3:0]  step;
    logic [11:0] code;
    logic [11:0] res;
    logic        done;
  } sac_sar_st_t;

  sac_sar_st_t st_r;
  sac_sar_st_t st_nxt;

  always_comb begin
    logic [3:0] b;
    b = 4'h0;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (abort) begin
      st_nxt.run = 1'b0;
    end else if (start) begin
      st_nxt.run  = 1'b1;
      st_nxt.step = 4'h0;
      st_nxt.code = sac_pkg::SAC_MSB_TRIAL;
    end else if (st_r.run && tick) begin
      if (st_r.step < 4'(sac_pkg::SAC_RES_W)) begin
        b = 4'(sac_pkg::SAC_RES_W - 1) - st_r.step;
        // A low comparator means the trial overshot the input.
        if (!cmp) begin
          st_nxt.code[b] = 1'b0;
        end
        if (b != 4'h0) begin
          st_nxt.code[b - 4'h1] = 1'b1;
        end
      end
      if (st_r.step == 4'(sac_pkg::SAC_CONV_CLKS - 1)) begin
        st_nxt.run  = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.res  = st_r.code;
      end else begin
        st_nxt.step = st_r.step + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done     = st_r.done;
  assign result   = st_r.res;
  assign dac_code = st_r.code;

  a_done_single: assert property (@(posedge clk) disable iff (!rst_n)
    done |=> !done)
    else $error("conversion done lasted more than one cycle");

endmodule : sac_sar

// ==== design/sac_ctrl.sv ====
/*
  Converter control block: APB register file, start-source selection,
  tracking and conversion sequencing, completion and window flags, and
  result justification. Assumes one 50 MHz clock; timer overflows are
  one-cycle pulses on that clock, the start pin and comparator are async.
*/
// Added by the designer: the register addresses and the APB register port.
// Summary of operation
// R1: Enable bit clear keeps the converter in shutdown; set allows conversions.
// R2: Track mode clear and enabled: track continuously unless converting.
// R3: Completion flag set when the busy indication falls.
// R4: Busy reads one while converting, zero otherwise.
// R5: Mode 0, source 00: writing one to busy launches a conversion.
// R6: Mode 0, source 01: third timer overflow launches a conversion.
// R7: Mode 0, source 10: start pin rising edge launches a conversion.
// R8: Mode 0, source 11: second timer overflow launches a conversion.
// R9: Mode 1, source 00: busy write tracks three converter clocks, converts.
// R10: Mode 1, source 01: third timer overflow tracks three clocks, converts.
// R11: Mode 1, source 10: track while pin low, convert on rising edge.
// R12: Mode 1, source 11: second timer overflow tracks three clocks, converts.
// R13: Window flag set when a result falls in the programmed alert region.
// R14: Right justify puts result low with zero or sign top; left zeroes low.
// R15: Flags stay set until software clears them; writing busy zero is void.
module sac_ctrl (
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire sac_pkg::sac_apb_req_t APB_REQ,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  TMR2_OVF,
  input  wire logic                  TMR3_OVF,
  input  wire logic                  EXTERNAL_CONVERT_START_PIN,
  input  wire logic                  DIFF_MODE,
  input  wire logic                  CMP_IN,
  output logic                       ADC_PWR_EN,
  output logic                       ADC_TRACK,
  output logic [11:0]                DAC_CODE
);

  typedef struct packed {
    logic                converter_enable;
    logic                track_mode_select;
    logic                conversion_done_flag;
    logic [1:0]          start_source;
    logic                window_compare_flag;
    logic                left_justify;
    sac_pkg::sac_phase_t phase;
    logic [1:0]          tcnt;
    logic [4:0]          div;
    logic [5:0]          dcnt;
    logic [15:0]         gt;
    logic [15:0]         lt;
    logic [11:0]         res;
    logic                cmp_s1;
    logic                cmp_s2;
    logic                cnv_s1;
    logic                cnv_s2;
    logic                cnv_q;
    logic                track;
    logic [31:0]         rdata;
  } sac_st_t;

  localparam sac_st_t ST_RST = '{
    converter_enable:     sac_pkg::SAC_CTRL_RST[sac_pkg::SAC_B_EN],
    track_mode_select:    sac_pkg::SAC_CTRL_RST[sac_pkg::SAC_B_TM],
    conversion_done_flag: sac_pkg::SAC_CTRL_RST[sac_pkg::SAC_B_DONE],
    start_source:         sac_pkg::SAC_CTRL_RST[sac_pkg::SAC_B_SRC +: 2],
    window_compare_flag:  sac_pkg::SAC_CTRL_RST[sac_pkg::SAC_B_WINT],
    left_justify:         sac_pkg::SAC_CTRL_RST[sac_pkg::SAC_B_LJST],
    phase:                sac_pkg::SAC_IDLE,
    div:                  sac_pkg::SAC_DIV_RST,
    gt:                   sac_pkg::SAC_GT_RST,
    lt:                   sac_pkg::SAC_LT_RST,
    default:              '0
  };

  sac_st_t     st_r;
  sac_st_t     st_nxt;
  logic        tick;
  logic        sw_go;
  logic        start_evt;
  logic        pin_rise;
  logic        sar_start;
  logic        sar_abort;
  logic        sar_done;
  logic [11:0] sar_result;
  logic        setup;
  logic        wr;
  logic        busy;

  // Places the 12-bit result in the 16-bit data word.
  function automatic logic [15:0] justify(logic [11:0] r, logic lj,
                                          logic sgn);
    return lj ? {r, 4'h0} : {{4{sgn & r[11]}}, r};
  endfunction : justify

  // Widens a data word so that signed and unsigned words compare alike.
  function automatic logic signed [16:0] widen(logic [15:0] v, logic sgn);
    return $signed({sgn & v[15], v});
  endfunction : widen

  // Limits in order give an inside window, reversed ones an outside window.
  function automatic logic win_hit(logic [15:0] v, logic [15:0] gt,
                                   logic [15:0] lt, logic sgn);
    logic signed [16:0] sv;
    logic signed [16:0] sg;
    logic signed [16:0] sl;
    sv = widen(v, sgn);
    sg = widen(gt, sgn);
    sl = widen(lt, sgn);
    if (sl > sg) begin
      return (sv > sg) && (sv < sl);
    end
    return (sv > sg) || (sv < sl);
  endfunction : win_hit

  function automatic logic mapped(logic [7:0] a);
    return a == sac_pkg::SAC_OFF_CTRL || a == sac_pkg::SAC_OFF_RESULT ||
           a == sac_pkg::SAC_OFF_GT   || a == sac_pkg::SAC_OFF_LT ||
           a == sac_pkg::SAC_OFF_DIV  || a == sac_pkg::SAC_OFF_STAT;
  endfunction : mapped

  assign busy     = st_r.phase != sac_pkg::SAC_IDLE;
  assign setup    = APB_REQ.psel & ~APB_REQ.penable;
  assign wr       = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
  assign pin_rise = st_r.cnv_s2 & ~st_r.cnv_q;

  always_comb begin
    st_nxt    = st_r;
    tick      = 1'b0;
    sw_go     = 1'b0;
    start_evt = 1'b0;
    sar_start = 1'b0;
    sar_abort = 1'b0;

    // Async inputs pass two flops before any logic looks at them.
    st_nxt.cmp_s1 = CMP_IN;
    st_nxt.cmp_s2 = st_r.cmp_s1;
    st_nxt.cnv_s1 = EXTERNAL_CONVERT_START_PIN;
    st_nxt.cnv_s2 = st_r.cnv_s1;
    st_nxt.cnv_q  = st_r.cnv_s2;

    // Converter clock enable, one pulse every 2*(div+1) system clocks.
    if (st_r.converter_enable) begin
      if (st_r.dcnt == 6'h00) begin
        tick        = 1'b1;
        st_nxt.dcnt = {st_r.div, 1'b1};
      end else begin
        st_nxt.dcnt = st_r.dcnt - 6'h01;
      end
    end else begin
      st_nxt.dcnt = 6'h00;
    end

    if (wr) begin
      case (APB_REQ.paddr)
        sac_pkg::SAC_OFF_CTRL: begin
          st_nxt.converter_enable     = APB_REQ.pwdata[sac_pkg::SAC_B_EN];
          st_nxt.track_mode_select    = APB_REQ.pwdata[sac_pkg::SAC_B_TM];
          st_nxt.conversion_done_flag = APB_REQ.pwdata[sac_pkg::SAC_B_DONE];
          st_nxt.start_source = APB_REQ.pwdata[sac_pkg::SAC_B_SRC +: 2];
          st_nxt.window_compare_flag  = APB_REQ.pwdata[sac_pkg::SAC_B_WINT];
          st_nxt.left_justify         = APB_REQ.pwdata[sac_pkg::SAC_B_LJST];
          sw_go = APB_REQ.pwdata[sac_pkg::SAC_B_BUSY]; // R15
        end
        sac_pkg::SAC_OFF_GT: begin
          st_nxt.gt = APB_REQ.pwdata[15:0];
        end
        sac_pkg::SAC_OFF_LT: begin
          st_nxt.lt = APB_REQ.pwdata[15:0];
        end
        sac_pkg::SAC_OFF_DIV: begin
          st_nxt.div = APB_REQ.pwdata[4:0];
        end
        default: begin
        end
      endcase
    end

    case (sac_pkg::sac_src_t'(st_nxt.start_source))
      sac_pkg::SAC_SRC_SW:   start_evt = sw_go;    // R5 R9
      sac_pkg::SAC_SRC_TMR3: start_evt = TMR3_OVF; // R6 R10
      sac_pkg::SAC_SRC_PIN:  start_evt = pin_rise; // R7 R11
      sac_pkg::SAC_SRC_TMR2: start_evt = TMR2_OVF; // R8 R12
      default:               start_evt = 1'b0;
    endcase

    // Requests that arrive while busy are ignored.
    case (st_r.phase)
      sac_pkg::SAC_IDLE: begin
        if (st_nxt.converter_enable && start_evt) begin
          if (st_nxt.track_mode_select &&
              st_nxt.start_source != sac_pkg::SAC_SRC_PIN) begin
            st_nxt.phase = sac_pkg::SAC_TRACK; // R9 R10 R12
            st_nxt.tcnt  = 2'h0;
          end else begin
            st_nxt.phase = sac_pkg::SAC_CONV; // R5 R6 R7 R8 R11
            sar_start    = 1'b1;
          end
        end
      end
      sac_pkg::SAC_TRACK: begin
        if (tick) begin
          if (st_r.tcnt == 2'(sac_pkg::SAC_TRACK_CLKS - 1)) begin
            st_nxt.phase = sac_pkg::SAC_CONV; // R9 R10 R12
            sar_start    = 1'b1;
          end else begin
            st_nxt.tcnt = st_r.tcnt + 2'h1;
          end
        end
      end
      sac_pkg::SAC_CONV: begin
        if (sar_done) begin
          st_nxt.phase = sac_pkg::SAC_IDLE;
          st_nxt.res   = sar_result;
          if (win_hit(justify(sar_result, st_nxt.left_justify, DIFF_MODE),
                      st_nxt.gt, st_nxt.lt, DIFF_MODE)) begin
            st_nxt.window_compare_flag = 1'b1; // R13
          end
        end
      end
      default: begin
        st_nxt.phase = sac_pkg::SAC_IDLE;
      end
    endcase

    // Disabling drops any conversion in flight and parks the converter.
    if (!st_nxt.converter_enable) begin
      st_nxt.phase = sac_pkg::SAC_IDLE; // R1
      sar_abort    = 1'b1;
    end

    // A start restarts the divider so that, for any div above 0, the first converter clock comes
    // only after the comparator has settled through its synchroniser.
    if (!busy && st_nxt.phase != sac_pkg::SAC_IDLE) begin
      st_nxt.dcnt = {st_r.div, 1'b1};
    end

    // Placed after the register write so that a set beats a clear.
    if (busy && st_nxt.phase == sac_pkg::SAC_IDLE) begin
      st_nxt.conversion_done_flag = 1'b1; // R3
    end

    if (!st_nxt.converter_enable) begin
      st_nxt.track = 1'b0; // R1
    end else if (!st_nxt.track_mode_select) begin
      st_nxt.track = st_nxt.phase != sac_pkg::SAC_CONV; // R2
    end else if (st_nxt.start_source == sac_pkg::SAC_SRC_PIN) begin
      st_nxt.track = st_nxt.phase == sac_pkg::SAC_IDLE & ~st_r.cnv_s2; // R11
    end else begin
      st_nxt.track = st_nxt.phase == sac_pkg::SAC_TRACK;
    end

    // Read data is captured in the setup cycle and held for the access.
    if (setup) begin
      case (APB_REQ.paddr)
        sac_pkg::SAC_OFF_CTRL: begin
          st_nxt.rdata = {24'h000000, st_r.converter_enable,
                          st_r.track_mode_select, st_r.conversion_done_flag,
                          busy, st_r.start_source, // R4
                          st_r.window_compare_flag, st_r.left_justify};
        end
        sac_pkg::SAC_OFF_RESULT: begin
          st_nxt.rdata = {16'h0000,
                          justify(st_r.res, st_r.left_justify,
                                  DIFF_MODE)}; // R14
        end
        sac_pkg::SAC_OFF_GT: begin
          st_nxt.rdata = {16'h0000, st_r.gt};
        end
        sac_pkg::SAC_OFF_LT: begin
          st_nxt.rdata = {16'h0000, st_r.lt};
        end
        sac_pkg::SAC_OFF_DIV: begin
          st_nxt.rdata = {27'h0000000, st_r.div};
        end
        sac_pkg::SAC_OFF_STAT: begin
          st_nxt.rdata = {27'h0000000, st_r.track, st_r.cnv_s2,
                          st_r.tcnt, st_r.phase == sac_pkg::SAC_CONV};
        end
        default: begin
          st_nxt.rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  sac_sar u_sar (
    .clk      (CLK),
    .rst_n    (RST_N),
    .tick     (tick),
    .start    (sar_start),
    .abort    (sar_abort),
    .cmp      (st_r.cmp_s2),
    .done     (sar_done),
    .result   (sar_result),
    .dac_code (DAC_CODE)
  );

  assign PRDATA     = st_r.rdata;
  assign PREADY     = 1'b1;
  assign PSLVERR    = APB_REQ.psel & APB_REQ.penable &
                      ~mapped(APB_REQ.paddr);
  assign ADC_PWR_EN = st_r.converter_enable;
  assign ADC_TRACK  = st_r.track;

  // Counts converter clocks spent tracking, for the a_track_three check below.
  logic [2:0] trk_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      trk_q <= 3'h0;
    end else if (st_r.phase == sac_pkg::SAC_IDLE) begin
      trk_q <= 3'h0;
    end else if (st_r.phase == sac_pkg::SAC_TRACK && tick) begin
      trk_q <= trk_q + 3'h1;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_idle_ready(logic [1:0] s);
    st_r.phase == sac_pkg::SAC_IDLE && st_r.converter_enable &&
    st_r.start_source == s &&
    !(wr && APB_REQ.paddr == sac_pkg::SAC_OFF_CTRL);
  endsequence

  sequence s_track_to_conv;
    st_r.phase == sac_pkg::SAC_TRACK ##1 st_r.phase == sac_pkg::SAC_CONV;
  endsequence

  sequence s_sw_start;
    st_r.phase == sac_pkg::SAC_IDLE && wr &&
    APB_REQ.paddr == sac_pkg::SAC_OFF_CTRL &&
    APB_REQ.pwdata[sac_pkg::SAC_B_EN] &&
    APB_REQ.pwdata[sac_pkg::SAC_B_BUSY] &&
    APB_REQ.pwdata[sac_pkg::SAC_B_SRC +: 2] == 2'h0;
  endsequence

  a_shutdown_idle: assert property ( // R1
    !ADC_PWR_EN |-> !busy && !ADC_TRACK)
    else $error("converter active while disabled");

  a_continuous_track: assert property ( // R2
    ADC_PWR_EN && !st_r.track_mode_select &&
    st_r.phase != sac_pkg::SAC_CONV |-> ADC_TRACK)
    else $error("continuous tracking missing");

  a_done_on_fall: assert property ( // R3
    $fell(busy) |-> st_r.conversion_done_flag)
    else $error("done flag not set at busy fall");

  a_busy_readback: assert property ( // R4
    setup && !APB_REQ.pwrite && APB_REQ.paddr == sac_pkg::SAC_OFF_CTRL
    |=> PRDATA[sac_pkg::SAC_B_BUSY] == $past(busy))
    else $error("busy bit read back wrong");

  a_sw_launch: assert property ( // R5
    s_sw_start |=> busy)
    else $error("software start ignored");

  a_tmr3_launch: assert property ( // R6
    s_idle_ready(2'h1) ##0 TMR3_OVF |=> busy ##1 busy)
    else $error("third timer start ignored");

  a_pin_launch: assert property ( // R7
    s_idle_ready(2'h2) ##0 pin_rise |=> st_r.phase == sac_pkg::SAC_CONV)
    else $error("pin start ignored");

  a_tmr2_launch: assert property ( // R8
    s_idle_ready(2'h3) ##0 TMR2_OVF |=> busy)
    else $error("second timer start ignored");

  a_track_three: assert property ( // R9
    s_track_to_conv |-> trk_q == 3'h3)
    else $error("tracking did not last three converter clocks");

  a_pin_tracking: assert property ( // R11
    ADC_PWR_EN && st_r.track_mode_select &&
    st_r.start_source == 2'h2 && ADC_TRACK |-> !$past(st_r.cnv_s2))
    else $error("tracking while start pin high");

  a_window_flag: assert property ( // R13
    st_r.phase == sac_pkg::SAC_CONV && sar_done && st_r.converter_enable &&
    win_hit(justify(sar_result, st_r.left_justify, DIFF_MODE),
            st_r.gt, st_r.lt, DIFF_MODE) |=> st_r.window_compare_flag)
    else $error("window flag not set");

  a_left_justify: assert property ( // R14
    setup && !APB_REQ.pwrite && st_r.left_justify &&
    APB_REQ.paddr == sac_pkg::SAC_OFF_RESULT
    |=> PRDATA[3:0] == 4'h0 && PRDATA[15:4] == $past(st_r.res))
    else $error("left justified result misplaced");

endmodule : sac_ctrl

// ==== bench/sac_analog_model.sv ====
/*
  Behavioural comparator that stands at the converter's analog side.
  Assumes the control block presents its trial code on the DAC bus and
  re-synchronises the comparator output itself.
*/
module sac_analog_model (
  input  wire logic [11:0] dac_code,
  input  wire logic [11:0] level,
  input  wire logic        powered,
  output logic             cmp
);
  timeunit 1ns;
  timeprecision 1ps;

  // The input sits half a code above level, so no trial code is ever a tie.
  assign cmp = powered && ({dac_code, 1'b0} < {level, 1'b1});
endmodule : sac_analog_model

// ==== bench/sac_ctrl_tb.sv ====
/*
  Self-checking bench for the converter control block: APB access tasks,
  start-source sweeps in both track modes, flags and justification.
  Assumes the design package and the comparator model are compiled first.
*/
module sac_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk;
  logic                  rst_n;
  sac_pkg::sac_apb_req_t req;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  tmr2;
  logic                  tmr3;
  logic                  pin;
  logic                  diff;
  logic                  cmp;
  logic                  pwr;
  logic                  track;
  logic [11:0]           dac;
  logic [11:0]           level;
  logic [31:0]           rd;
  logic                  err;
  logic [7:0]            base;
  int                    t;
  int                    s;
  int                    k;
  int                    error_cnt;
  int                    num_checks;

  sac_ctrl sac_ctrl_inst (
    .CLK                        (clk),
    .RST_N                      (rst_n),
    .APB_REQ                    (req),
    .PRDATA                     (prdata),
    .PREADY                     (pready),
    .PSLVERR                    (pslverr),
    .TMR2_OVF                   (tmr2),
    .TMR3_OVF                   (tmr3),
    .EXTERNAL_CONVERT_START_PIN (pin),
    .DIFF_MODE                  (diff),
    .CMP_IN                     (cmp),
    .ADC_PWR_EN                 (pwr),
    .ADC_TRACK                  (track),
    .DAC_CODE                   (dac)
  );

  sac_analog_model sac_analog_model_inst (
    .dac_code (dac),
    .level    (level),
    .powered  (pwr),
    .cmp      (cmp)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task give_verdict;
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask : apb

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, '0);
    chk(rd, exp, what);
  endtask : rdchk

  // Raises one start event: 0 busy write, 1 and 3 timers, 2 the pin.
  task fire(input int src);
    if (src == 0) begin
      apb(1'b1, sac_pkg::SAC_OFF_CTRL, {24'h0, base | 8'h10});
    end else if (src == 2) begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      pin <= 1'b0;
    end else begin
      @(posedge clk);
      tmr3 <= (src == 1);
      tmr2 <= (src == 3);
      @(posedge clk);
      tmr3 <= 1'b0;
      tmr2 <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask : fire

  task wait_done(input logic [7:0] exp_ctrl, input logic [31:0] exp_res);
    int n;
    n = 0;
    do begin
      apb(1'b0, sac_pkg::SAC_OFF_CTRL, '0);
      n++;
    end while (rd[4] !== 1'b0 && n < 100);
    chk(rd, {24'h0, exp_ctrl}, "control after conversion");
    rdchk(sac_pkg::SAC_OFF_RESULT, exp_res, "result word");
  endtask : wait_done

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    tmr2 = 1'b0;
    tmr3 = 1'b0;
    pin = 1'b0;
    diff = 1'b0;
    level = 12'h5A3;
    base = 8'h00;
    error_cnt = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(sac_pkg::SAC_OFF_CTRL, 32'h0, "control reset");
    rdchk(sac_pkg::SAC_OFF_GT, 32'h0000FFFF, "upper limit reset");
    rdchk(sac_pkg::SAC_OFF_LT, 32'h0, "lower limit reset");
    rdchk(sac_pkg::SAC_OFF_DIV, 32'h1F, "divider reset");
    rdchk(sac_pkg::SAC_OFF_RESULT, 32'h0, "result reset");
    rdchk(sac_pkg::SAC_OFF_STAT, 32'h0, "status reset");
    chk(32'(pwr), 32'h0, "powered in shutdown");
    apb(1'b0, 8'h40, '0);
    chk({31'h0, err}, 32'h1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b1, sac_pkg::SAC_OFF_DIV, 32'h1);
    apb(1'b1, sac_pkg::SAC_OFF_CTRL, 32'h10);
    rdchk(sac_pkg::SAC_OFF_CTRL, 32'h0, "start while disabled");
    for (t = 0; t < 2; t++) begin
      for (s = 0; s < 4; s++) begin
        base = {1'b1, t[0], 2'b00, s[1:0], 2'b00};
        apb(1'b1, sac_pkg::SAC_OFF_CTRL, {24'h0, base});
        @(posedge clk);
        #1;
        chk(32'(pwr), 32'h1, "powered when enabled");
        if (t == 0) chk(32'(track), 32'h1, "idle tracking");
        for (k = 0; k < 4; k++) begin
          if (k != s) begin
            fire(k);
            rdchk(sac_pkg::SAC_OFF_CTRL, {24'h0, base}, "foreign start");
          end
        end
        if (t == 1 && s == 2) chk(32'(track), 32'h1, "track pin low");
        fire(s);
        chk(32'(track), 32'(t == 1 && s != 2), "track phase");
        apb(1'b0, sac_pkg::SAC_OFF_CTRL, '0);
        chk({31'h0, rd[4]}, 32'h1, "busy while converting");
        wait_done(base | 8'h20, 32'h000005A3);
        chk({20'h0, dac}, 32'h000005A3, "final trial code");
        if (t == 0) chk(32'(track), 32'h1, "tracking resumes");
        apb(1'b1, sac_pkg::SAC_OFF_CTRL, {24'h0, base});
        rdchk(sac_pkg::SAC_OFF_CTRL, {24'h0, base}, "flag clear");
      end
    end
    base = 8'h81;
    apb(1'b1, sac_pkg::SAC_OFF_GT, 32'h100);
    apb(1'b1, sac_pkg::SAC_OFF_CTRL, {24'h0, base});
    fire(0);
    wait_done(8'hA3, 32'h00005A30);
    base = 8'h80;
    diff <= 1'b1;
    level <= 12'hA5C;
    apb(1'b1, sac_pkg::SAC_OFF_CTRL, {24'h0, base});
    fire(0);
    wait_done(8'hA2, 32'h0000FA5C);
    apb(1'b1, sac_pkg::SAC_OFF_CTRL, {24'h0, base});
    fire(0);
    apb(1'b1, sac_pkg::SAC_OFF_CTRL, 32'h0);
    @(posedge clk);
    #1;
    chk(32'(pwr), 32'h0, "shutdown after disable");
    rdchk(sac_pkg::SAC_OFF_CTRL, 32'h20, "abort ends busy");
    give_verdict();
  end
endmodule : sac_ctrl_tb
